// File: hw/aam_datapath.sv
/*
  accumulator, alu, saturation, overflow flag, branch conditions, plus the
  multiplier and output shifter. assumes the decoder presents one operation per
  cycle and a store request alongside; all ops complete in one cycle.
*/
`timescale 1ns/1ns
`include "aam_defs.svh"
module aam_datapath (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire aam_pkg::aam_cmd_s i_cmd,
  input wire aam_pkg::aam_store_s i_store,
  output logic [31:0] o_acc,
  output logic [31:0] o_product,
  output aam_pkg::aam_cond_s o_cond,
  output logic o_saturation_enable,
  output logic o_branch_on_overflow_taken,
  output logic o_int_hold,
  output logic [15:0] o_wdata,
  output logic o_wvalid
);
  import aam_pkg::*;

  logic [31:0] acc_ff;
  logic [31:0] nxt_acc;
  logic sat_ff;
  logic ovf_ff;
  logic hold_ff;
  logic [31:0] shifted_in;
  logic [31:0] operand_b;
  logic [31:0] sum;
  logic is_sub;
  logic is_arith;
  logic ovf_now;
  logic [15:0] status_word;
  logic [15:0] t_word;
  logic ld_opnd;

  // overflow when operand signs agree and result sign differs
  function automatic logic signed_ovf(input logic [31:0] a, input logic [31:0] b,
                                      input logic [31:0] s);
    signed_ovf = (a[31] == b[31]) && (s[31] != a[31]);
  endfunction

  // arithmetic left shift of a 16-bit word into 32 bits
  function automatic logic [31:0] scale_in(input logic [15:0] d, input logic [4:0] sh);
    logic [31:0] ext;
    ext = {{16{d[15]}}, d};
    scale_in = ext << sh;
  endfunction

  assign ld_opnd = i_cmd.op == AAM_LOAD_OPND || i_cmd.op == AAM_LOAD_OPND_ACC
                   || i_cmd.op == AAM_LOAD_OPND_MOVE;

  aam_multiplier u_mult (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_load_opnd(ld_opnd),
    .i_mult(i_cmd.op == AAM_MULT),
    .i_mult_imm(i_cmd.op == AAM_MULT_IMM),
    .i_data(i_cmd.data),
    .i_imm(i_cmd.imm),
    .o_product(o_product),
    .o_operand(t_word)
  );

  // shift amounts above 16 clamp to 16
  assign shifted_in = scale_in(i_cmd.data, (i_cmd.in_shift > 5'h10) ? 5'h10
                                            : i_cmd.in_shift);

  // load-operand-accumulate adds the product as it reloads the operand
  always_comb begin
    if (i_cmd.op == AAM_ADD_PROD || i_cmd.op == AAM_SUB_PROD
        || i_cmd.op == AAM_PROD_TO_ACC || i_cmd.op == AAM_LOAD_OPND_ACC
        || i_cmd.op == AAM_LOAD_OPND_MOVE) begin
      operand_b = o_product;
    end else begin
      operand_b = shifted_in;
    end
  end

  assign is_sub = i_cmd.op == AAM_SUB || i_cmd.op == AAM_SUB_PROD;
  assign is_arith = i_cmd.op == AAM_ADD || i_cmd.op == AAM_SUB || i_cmd.op == AAM_ADD_PROD
                    || i_cmd.op == AAM_SUB_PROD || i_cmd.op == AAM_LOAD_OPND_ACC
                    || i_cmd.op == AAM_LOAD_OPND_MOVE;
  // subtraction checked as addition of the negated operand
  assign sum = is_sub ? acc_ff - operand_b : acc_ff + operand_b;
  assign ovf_now = is_arith && signed_ovf(acc_ff, is_sub ? ~operand_b + 32'h1 : operand_b,
                                          sum);

  always_comb begin
    nxt_acc = acc_ff;
    case (i_cmd.op)
      AAM_LOAD: nxt_acc = shifted_in;
      AAM_PROD_TO_ACC: nxt_acc = o_product;
      AAM_XOR: nxt_acc = {acc_ff[31:16] ^ 16'h0000, acc_ff[15:0] ^ i_cmd.data};
      AAM_AND: nxt_acc = {acc_ff[31:16] & 16'h0000, acc_ff[15:0] & i_cmd.data};
      AAM_OR: nxt_acc = {acc_ff[31:16] | 16'h0000, acc_ff[15:0] | i_cmd.data};
      AAM_ADD, AAM_SUB, AAM_ADD_PROD, AAM_SUB_PROD, AAM_LOAD_OPND_ACC,
      AAM_LOAD_OPND_MOVE: begin
        if (ovf_now && sat_ff) begin
          nxt_acc = acc_ff[31] ? `AAM_SAT_NEG : `AAM_SAT_POS;
        end else begin
          nxt_acc = sum;
        end
      end
      default: nxt_acc = acc_ff;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      acc_ff <= `AAM_ACC_RST;
    end else begin
      acc_ff <= nxt_acc;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      sat_ff <= 1'b0;
    end else if (i_cmd.op == AAM_SET_SAT) begin
      sat_ff <= 1'b1;
    end else if (i_cmd.op == AAM_CLR_SAT) begin
      sat_ff <= 1'b0;
    end else if (i_cmd.op == AAM_LOAD_STATUS) begin
      sat_ff <= i_cmd.data[`AAM_ST_SAT_BIT];
    end
  end

  // branch and status load are never arithmetic, so no set/clear collision
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      ovf_ff <= 1'b0;
    end else if (ovf_now) begin
      ovf_ff <= 1'b1;
    end else if (i_cmd.op == AAM_BR_OVF) begin
      ovf_ff <= 1'b0;
    end else if (i_cmd.op == AAM_LOAD_STATUS) begin
      ovf_ff <= i_cmd.data[`AAM_ST_OVF_BIT];
    end
  end

  // covers the cycle of the following instruction
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      hold_ff <= 1'b0;
    end else begin
      hold_ff <= i_cmd.op == AAM_MULT || i_cmd.op == AAM_MULT_IMM;
    end
  end

  always_comb begin
    status_word = 16'h0000;
    status_word[`AAM_ST_OVF_BIT] = ovf_ff;
    status_word[`AAM_ST_SAT_BIT] = sat_ff;
  end

  aam_out_shifter u_osh (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_store(i_store),
    .i_acc(acc_ff),
    .i_status(status_word),
    .o_wdata(o_wdata),
    .o_wvalid(o_wvalid)
  );

  assign o_acc = acc_ff;
  assign o_saturation_enable = sat_ff;
  assign o_branch_on_overflow_taken = i_cmd.op == AAM_BR_OVF && ovf_ff;
  assign o_int_hold = hold_ff || i_cmd.op == AAM_MULT || i_cmd.op == AAM_MULT_IMM;
  assign o_cond.lt_zero = acc_ff[31];
  assign o_cond.le_zero = acc_ff[31] || acc_ff == 32'h0;
  assign o_cond.ge_zero = !acc_ff[31];
  assign o_cond.gt_zero = !acc_ff[31] && acc_ff != 32'h0;
  assign o_cond.ne_zero = acc_ff != 32'h0;
  assign o_cond.eq_zero = acc_ff == 32'h0;
  assign o_cond.overflow = ovf_ff;

  property p_logic_high_zero;
    @(posedge i_clock) disable iff (!i_rst_n)
    (i_cmd.op == AAM_AND) |=> o_acc[31:16] == 16'h0000;
  endproperty
  a_logic_high_zero: assert property (p_logic_high_zero) else $error("and high not zero");

  property p_sat_pos;
    @(posedge i_clock) disable iff (!i_rst_n)
    (ovf_now && sat_ff && !acc_ff[31]) |=> o_acc == 32'h7fff_ffff;
  endproperty
  a_sat_pos: assert property (p_sat_pos) else $error("positive saturation wrong");

  property p_wrap;
    @(posedge i_clock) disable iff (!i_rst_n)
    (is_arith && !sat_ff) |=> o_acc == $past(sum);
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrapped result wrong");

  property p_ovf_set;
    @(posedge i_clock) disable iff (!i_rst_n)
    ovf_now |=> o_cond.overflow;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set");

  property p_ovf_sticky;
    @(posedge i_clock) disable iff (!i_rst_n)
    (ovf_ff && i_cmd.op != AAM_BR_OVF && i_cmd.op != AAM_LOAD_STATUS) |=> ovf_ff;
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag lost");

  property p_sat_ctl;
    @(posedge i_clock) disable iff (!i_rst_n)
    i_cmd.op == AAM_SET_SAT |=> o_saturation_enable;
  endproperty
  a_sat_ctl: assert property (p_sat_ctl) else $error("saturation not enabled");

  property p_hold;
    @(posedge i_clock) disable iff (!i_rst_n)
    i_cmd.op == AAM_MULT |-> o_int_hold ##1 o_int_hold;
  endproperty
  a_hold: assert property (p_hold) else $error("interrupt hold short");

  property p_pac;
    @(posedge i_clock) disable iff (!i_rst_n)
    i_cmd.op == AAM_PROD_TO_ACC |=> o_acc == $past(o_product);
  endproperty
  a_pac: assert property (p_pac) else $error("product load wrong");

  // shift codes above 16 must behave as 16
  property p_load_top;
    @(posedge i_clock) disable iff (!i_rst_n)
    (i_cmd.op == AAM_LOAD && i_cmd.in_shift >= 5'h10)
      |=> o_acc == {$past(i_cmd.data), 16'h0000};
  endproperty
  a_load_top: assert property (p_load_top) else $error("load shift 16 wrong");

  property p_sat_neg;
    @(posedge i_clock) disable iff (!i_rst_n)
    (ovf_now && sat_ff && acc_ff[31]) |=> o_acc == 32'h8000_0000;
  endproperty
  a_sat_neg: assert property (p_sat_neg) else $error("negative saturation wrong");

  property p_br_clear;
    @(posedge i_clock) disable iff (!i_rst_n)
    i_cmd.op == AAM_BR_OVF |=> !o_cond.overflow;
  endproperty
  a_br_clear: assert property (p_br_clear) else $error("branch left flag set");

  property p_status_load;
    @(posedge i_clock) disable iff (!i_rst_n)
    i_cmd.op == AAM_LOAD_STATUS |=> o_cond.overflow == $past(i_cmd.data[`AAM_ST_OVF_BIT])
      && o_saturation_enable == $past(i_cmd.data[`AAM_ST_SAT_BIT]);
  endproperty
  a_status_load: assert property (p_status_load) else $error("status load wrong");

  property p_sat_clr;
    @(posedge i_clock) disable iff (!i_rst_n)
    i_cmd.op == AAM_CLR_SAT |=> !o_saturation_enable;
  endproperty
  a_sat_clr: assert property (p_sat_clr) else $error("saturation not cleared");

  property p_store_keeps;
    @(posedge i_clock) disable iff (!i_rst_n)
    (i_store.sel != AAM_ST_NONE && i_cmd.op == AAM_NOP) |=> $stable(o_acc);
  endproperty
  a_store_keeps: assert property (p_store_keeps) else $error("store changed acc");

  property p_cond_consistent;
    @(posedge i_clock) disable iff (!i_rst_n)
    o_cond.le_zero == (o_cond.lt_zero || o_cond.eq_zero) && o_cond.gt_zero == !o_cond.le_zero
      && o_cond.ge_zero == !o_cond.lt_zero && o_cond.ne_zero == !o_cond.eq_zero;
  endproperty
  a_cond_consistent: assert property (p_cond_consistent) else $error("conditions clash");

  property p_logic_no_ovf;
    @(posedge i_clock) disable iff (!i_rst_n)
    (i_cmd.op inside {AAM_XOR, AAM_AND, AAM_OR} && !ovf_ff) |=> !ovf_ff;
  endproperty
  a_logic_no_ovf: assert property (p_logic_no_ovf) else $error("logic op overflowed");

  property p_opnd_acc;
    @(posedge i_clock) disable iff (!i_rst_n)
    (i_cmd.op == AAM_LOAD_OPND_ACC && !ovf_now)
      |=> t_word == $past(i_cmd.data) && o_acc == $past(acc_ff + o_product);
  endproperty
  a_opnd_acc: assert property (p_opnd_acc) else $error("operand-accumulate wrong");

  property p_sub_ovf;
    @(posedge i_clock) disable iff (!i_rst_n)
    (i_cmd.op == AAM_SUB && acc_ff[31] != shifted_in[31] && sum[31] != acc_ff[31])
      |=> o_cond.overflow;
  endproperty
  a_sub_ovf: assert property (p_sub_ovf) else $error("subtract overflow missed");
endmodule

// File: hw/aam_defs.svh
/*
  constants for the accumulator / multiplier datapath: widths, saturation values,
  shift codes. assumes nothing; definitions only.
*/
`ifndef AAM_DEFS_SVH
`define AAM_DEFS_SVH
`define AAM_ACC_RST 32'h0000_0000
`define AAM_PROD_RST 32'h0000_0000
`define AAM_OPND_RST 16'h0000
`define AAM_SAT_POS 32'h7fff_ffff
`define AAM_SAT_NEG 32'h8000_0000
`define AAM_IMM_W 13
`define AAM_OSH_0 2'h0
`define AAM_OSH_1 2'h1
`define AAM_OSH_4 2'h2
`define AAM_ST_OVF_BIT 12
`define AAM_ST_SAT_BIT 11
`endif

// File: hw/aam_pkg.sv
/*
  types for the accumulator / multiplier datapath.
  assumes the decoder drives one aam_op_e code per cycle.
*/
package aam_pkg;
  typedef enum logic [4:0] {
    AAM_NOP = 5'h00,
    AAM_LOAD = 5'h01,
    AAM_ADD = 5'h02,
    AAM_SUB = 5'h03,
    AAM_XOR = 5'h04,
    AAM_AND = 5'h05,
    AAM_OR = 5'h06,
    AAM_SET_SAT = 5'h07,
    AAM_CLR_SAT = 5'h08,
    AAM_LOAD_OPND = 5'h09,
    AAM_LOAD_OPND_ACC = 5'h0a,
    AAM_LOAD_OPND_MOVE = 5'h0b,
    AAM_MULT = 5'h0c,
    AAM_MULT_IMM = 5'h0d,
    AAM_PROD_TO_ACC = 5'h0e,
    AAM_ADD_PROD = 5'h0f,
    AAM_SUB_PROD = 5'h10,
    AAM_BR_OVF = 5'h11,
    AAM_LOAD_STATUS = 5'h12
  } aam_op_e;
  typedef enum logic [1:0] {
    AAM_ST_NONE = 2'h0,
    AAM_ST_HIGH = 2'h1,
    AAM_ST_LOW = 2'h2,
    AAM_ST_STATUS = 2'h3
  } aam_store_e;
  typedef struct packed {
    aam_op_e op;
    logic [4:0] in_shift;
    logic [12:0] imm;
    logic [15:0] data;
  } aam_cmd_s;
  typedef struct packed {
    aam_store_e sel;
    logic [1:0] out_shift;
  } aam_store_s;
  typedef struct packed {
    logic lt_zero;
    logic le_zero;
    logic ge_zero;
    logic gt_zero;
    logic ne_zero;
    logic eq_zero;
    logic overflow;
  } aam_cond_s;
endpackage

// File: hw/aam_multiplier.sv
/*
  signed 16x16 multiplier with operand and product registers.
  assumes decoder strobes are one-cycle and mutually exclusive.
*/
`timescale 1ns/1ns
`include "aam_defs.svh"
module aam_multiplier (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_load_opnd,
  input wire logic i_mult,
  input wire logic i_mult_imm,
  input wire logic [15:0] i_data,
  input wire logic [12:0] i_imm,
  output logic [31:0] o_product,
  output logic [15:0] o_operand
);
  logic [15:0] opnd_ff;
  logic [31:0] prod_ff;
  logic signed [15:0] second;

  // immediate right-justified, sign-extended
  assign second = i_mult_imm ? {{3{i_imm[12]}}, i_imm} : i_data;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      opnd_ff <= `AAM_OPND_RST;
    end else if (i_load_opnd) begin
      opnd_ff <= i_data;
    end
  end

  // 31 product bits sign-extended; only 8000h squared sets bit 30 apart from bit 31
  function automatic logic [31:0] mul_ext(input logic [15:0] a, input logic [15:0] b);
    logic [31:0] full;
    full = $signed(a) * $signed(b);
    mul_ext = {full[30], full[30:0]};
  endfunction

  // 8000h*8000h lands on c0000000h with no special case
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      prod_ff <= `AAM_PROD_RST;
    end else if (i_mult || i_mult_imm) begin
      prod_ff <= mul_ext(opnd_ff, second);
    end
  end

  assign o_product = prod_ff;
  assign o_operand = opnd_ff;

  property p_prod_one_cycle;
    @(posedge i_clock) disable iff (!i_rst_n)
    i_mult |=> o_product == mul_ext($past(opnd_ff), $past(i_data));
  endproperty
  a_prod_one_cycle: assert property (p_prod_one_cycle) else $error("product wrong");

  property p_imm_ext;
    @(posedge i_clock) disable iff (!i_rst_n)
    i_mult_imm |=> o_product ==
      mul_ext($past(opnd_ff), {{3{$past(i_imm[12])}}, $past(i_imm)});
  endproperty
  a_imm_ext: assert property (p_imm_ext) else $error("immediate product wrong");

  property p_opnd_load;
    @(posedge i_clock) disable iff (!i_rst_n)
    i_load_opnd |=> o_operand == $past(i_data);
  endproperty
  a_opnd_load: assert property (p_opnd_load) else $error("operand not loaded");

  property p_min_sq;
    @(posedge i_clock) disable iff (!i_rst_n)
    (i_mult && opnd_ff == 16'h8000 && i_data == 16'h8000) |=> o_product == 32'hc000_0000;
  endproperty
  a_min_sq: assert property (p_min_sq) else $error("min square wrong");
endmodule

// File: hw/aam_out_shifter.sv
/*
  accumulator output shifter and store-word selection, registered.
  assumes status word bits supplied by the caller.
*/
`timescale 1ns/1ns
`include "aam_defs.svh"
module aam_out_shifter (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire aam_pkg::aam_store_s i_store,
  input wire logic [31:0] i_acc,
  input wire logic [15:0] i_status,
  output logic [15:0] o_wdata,
  output logic o_wvalid
);
  import aam_pkg::*;
  logic [31:0] shifted;
  logic [15:0] wdata_ff;
  logic wvalid_ff;

  // top bits lost, low bits come from lower word
  always_comb begin
    if (i_store.out_shift == `AAM_OSH_1) begin
      shifted = {i_acc[30:0], 1'b0};
    end else if (i_store.out_shift == `AAM_OSH_4) begin
      shifted = {i_acc[27:0], 4'h0};
    end else begin
      shifted = i_acc;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      wdata_ff <= 16'h0000;
      wvalid_ff <= 1'b0;
    end else begin
      wvalid_ff <= i_store.sel != AAM_ST_NONE;
      case (i_store.sel)
        AAM_ST_HIGH: wdata_ff <= shifted[31:16];
        AAM_ST_LOW: wdata_ff <= i_acc[15:0];
        AAM_ST_STATUS: wdata_ff <= i_status;
        default: wdata_ff <= wdata_ff;
      endcase
    end
  end

  assign o_wdata = wdata_ff;
  assign o_wvalid = wvalid_ff;

  property p_high_shift4;
    @(posedge i_clock) disable iff (!i_rst_n)
    (i_store.sel == AAM_ST_HIGH && i_store.out_shift == `AAM_OSH_4)
      |=> o_wvalid && o_wdata == $past(i_acc[27:12]);
  endproperty
  a_high_shift4: assert property (p_high_shift4) else $error("high store shift wrong");

  property p_low;
    @(posedge i_clock) disable iff (!i_rst_n)
    i_store.sel == AAM_ST_LOW |=> o_wdata == $past(i_acc[15:0]);
  endproperty
  a_low: assert property (p_low) else $error("low store wrong");
endmodule

// File: tb/aam_decoder_model.sv
/*
  instruction decoder stand-in: presents one command and one store request a cycle.
  assumes the bench calls send from a single process.
*/
`timescale 1ns/1ns
module aam_decoder_model (
  input wire logic i_clock,
  output aam_pkg::aam_cmd_s o_cmd,
  output aam_pkg::aam_store_s o_store
);
  import aam_pkg::*;
  initial begin
    o_cmd = '0;
    o_store = '0;
  end
  // launched just after the edge, so the datapath takes it at the next one
  task automatic send(input aam_cmd_s c, input aam_store_s s);
    @(posedge i_clock);
    o_cmd <= c;
    o_store <= s;
  endtask
endmodule

// File: tb/alu_accumulator_multiplier_bench.sv
/*
  self-checking bench for the accumulator / multiplier datapath.
  assumes the decoder model in tb/ and the datapath files under hw/.
*/
`timescale 1ns/1ns
`include "aam_defs.svh"
module alu_accumulator_multiplier_bench;
  import aam_pkg::*;
  logic i_clock;
  logic i_rst_n;
  aam_cmd_s cmd;
  aam_store_s st;
  logic [31:0] acc;
  logic [31:0] prod;
  aam_cond_s cond;
  logic sat;
  logic bov;
  logic ihold;
  logic [15:0] wdata;
  logic wvalid;
  logic bov_seen;
  logic hold_seen;
  int miscompares = 0;
  int samples_checked = 0;
  aam_decoder_model u_dec (.i_clock(i_clock), .o_cmd(cmd), .o_store(st));
  aam_datapath u_dut (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_cmd(cmd), .i_store(st), .o_acc(acc),
    .o_product(prod), .o_cond(cond), .o_saturation_enable(sat),
    .o_branch_on_overflow_taken(bov), .o_int_hold(ihold), .o_wdata(wdata), .o_wvalid(wvalid)
  );
  initial begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end
  task automatic chk_w(input logic [31:0] g, input logic [31:0] e, input string m);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic chk_h(input logic [15:0] g, input logic [15:0] e, input string m);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic chk_b(input logic g, input logic e, input string m);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %0t %s got %b", $time, m, g);
    end
  endtask
  // branch conditions packed lt, le, ge, gt, ne, eq
  task automatic chk_cond(input logic [31:0] a);
    logic [5:0] e;
    e = {a[31], a[31] | (a == 32'h0), ~a[31], ~a[31] & (a != 32'h0), a != 32'h0, a == 32'h0};
    chk_w({26'h0, cond[6:1]}, {26'h0, e}, "cond");
  endtask
  // one op, then a nop; combinational flags are caught in the op's own cycle
  task automatic run(input aam_op_e op, input logic [15:0] d, input logic [4:0] sh = 5'h0,
                     input aam_store_e sel = AAM_ST_NONE, input logic [1:0] osh = 2'h0,
                     input logic [12:0] im = 13'h0);
    u_dec.send('{op: op, in_shift: sh, imm: im, data: d}, '{sel: sel, out_shift: osh});
    #1;
    bov_seen = bov;
    hold_seen = ihold;
    u_dec.send('0, '0);
    #1;
  endtask
  task automatic t_reset;
    chk_w(acc, 32'h0, "acc rst");
    chk_w(prod, 32'h0, "prod rst");
    chk_b(cond.overflow, 1'b0, "ovf rst");
    chk_b(sat, 1'b0, "sat rst");
    chk_b(wvalid, 1'b0, "wvalid rst");
    chk_cond(32'h0);
  endtask
  task automatic t_in_shift;
    run(AAM_LOAD, 16'h7ebc, 5'h4);
    chk_w(acc, 32'h0007_ebc0, "load 4");
    chk_cond(32'h0007_ebc0);
    run(AAM_LOAD, 16'h8ebc, 5'h8);
    chk_w(acc, 32'hff8e_bc00, "load 8");
    chk_cond(32'hff8e_bc00);
    run(AAM_LOAD, 16'h1234, 5'h1f);
    chk_w(acc, 32'h1234_0000, "load clamp");
    run(AAM_LOAD, 16'h8001, 5'h10);
    chk_w(acc, 32'h8001_0000, "load 16");
    run(AAM_ADD, 16'hffff);
    chk_w(acc, 32'h8000_ffff, "add");
    run(AAM_SUB, 16'h8000);
    chk_w(acc, 32'h8001_7fff, "sub");
    chk_b(cond.overflow, 1'b0, "no ovf");
  endtask
  task automatic t_logic;
    run(AAM_LOAD, 16'ha34b, 5'h10);
    run(AAM_OR, 16'h78cd);
    chk_w(acc, 32'ha34b_78cd, "or");
    run(AAM_XOR, 16'hffff);
    chk_w(acc, 32'ha34b_8732, "xor");
    run(AAM_AND, 16'h0f0f);
    chk_w(acc, 32'h0000_0702, "and");
    chk_b(cond.overflow, 1'b0, "logic ovf");
  endtask
  task automatic t_store;
    run(AAM_LOAD, 16'ha34b, 5'h10);
    run(AAM_OR, 16'h78cd);
    run(AAM_NOP, 16'h0, 5'h0, AAM_ST_HIGH, `AAM_OSH_4);
    chk_b(wvalid, 1'b1, "wvalid");
    chk_h(wdata, 16'h34b7, "high x16");
    chk_w(acc, 32'ha34b_78cd, "acc kept");
    run(AAM_NOP, 16'h0, 5'h0, AAM_ST_HIGH, `AAM_OSH_1);
    chk_h(wdata, 16'h4696, "high x2");
    run(AAM_NOP, 16'h0, 5'h0, AAM_ST_HIGH, `AAM_OSH_0);
    chk_h(wdata, 16'ha34b, "high");
    run(AAM_NOP, 16'h0, 5'h0, AAM_ST_LOW, `AAM_OSH_0);
    chk_h(wdata, 16'h78cd, "low");
    @(posedge i_clock);
    #1;
    chk_b(wvalid, 1'b0, "wvalid pulse");
  endtask
  task automatic t_overflow;
    run(AAM_LOAD, 16'h7fff, 5'h10);
    run(AAM_ADD, 16'h7fff, 5'h10);
    chk_w(acc, 32'hfffe_0000, "wrap");
    chk_b(cond.overflow, 1'b1, "ovf set");
    run(AAM_XOR, 16'hffff);
    chk_b(cond.overflow, 1'b1, "ovf sticky");
    run(AAM_BR_OVF, 16'h0);
    chk_b(bov_seen, 1'b1, "br taken");
    chk_b(cond.overflow, 1'b0, "ovf clr");
    run(AAM_BR_OVF, 16'h0);
    chk_b(bov_seen, 1'b0, "br idle");
  endtask
  task automatic t_saturate;
    run(AAM_SET_SAT, 16'h0);
    chk_b(sat, 1'b1, "sat on");
    run(AAM_LOAD, 16'h7fff, 5'h10);
    run(AAM_ADD, 16'h7fff, 5'h10);
    chk_w(acc, 32'h7fff_ffff, "sat pos");
    chk_b(cond.overflow, 1'b1, "sat ovf");
    run(AAM_NOP, 16'h0, 5'h0, AAM_ST_STATUS);
    chk_h(wdata, 16'h1800, "status");
    run(AAM_LOAD, 16'h8001, 5'h10);
    run(AAM_SUB, 16'h7fff, 5'h10);
    chk_w(acc, 32'h8000_0000, "sat neg");
    run(AAM_CLR_SAT, 16'h0);
    chk_b(sat, 1'b0, "sat off");
    run(AAM_BR_OVF, 16'h0);
    run(AAM_LOAD_STATUS, 16'h1000);
    chk_b(cond.overflow, 1'b1, "ld ovf");
    chk_b(sat, 1'b0, "ld sat");
    run(AAM_LOAD_STATUS, 16'h0800);
    chk_b(cond.overflow, 1'b0, "ld clr");
    chk_b(sat, 1'b1, "ld sat on");
    run(AAM_CLR_SAT, 16'h0);
  endtask
  task automatic t_mult;
    run(AAM_LOAD_OPND, 16'h8000);
    run(AAM_MULT, 16'h8000);
    chk_b(hold_seen, 1'b1, "hold mult");
    chk_b(ihold, 1'b1, "hold next");
    chk_w(prod, 32'hc000_0000, "min sq");
    run(AAM_PROD_TO_ACC, 16'h0);
    chk_b(hold_seen, 1'b0, "hold off");
    chk_w(acc, 32'hc000_0000, "to acc");
    run(AAM_LOAD_OPND, 16'h0003);
    run(AAM_MULT_IMM, 16'h1234, 5'h0, AAM_ST_NONE, 2'h0, 13'h1ffb);
    chk_w(prod, 32'hffff_fff1, "imm");
    run(AAM_ADD_PROD, 16'h0);
    chk_w(acc, 32'hbfff_fff1, "add prod");
    run(AAM_SUB_PROD, 16'h0);
    chk_w(acc, 32'hc000_0000, "sub prod");
    run(AAM_MULT, 16'hfffe);
    chk_w(prod, 32'hffff_fffa, "mult");
    run(AAM_LOAD_OPND_ACC, 16'h0002);
    chk_w(acc, 32'hbfff_fffa, "opnd acc");
    run(AAM_MULT, 16'h4000);
    chk_w(prod, 32'h0000_8000, "opnd 2");
    run(AAM_LOAD_OPND_MOVE, 16'h7fff);
    chk_w(acc, 32'hc000_7ffa, "opnd move");
    run(AAM_MULT, 16'h7fff);
    chk_w(prod, 32'h3fff_0001, "max sq");
  endtask
  task automatic report_and_stop;
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // about 90 cycles of work; over twenty times that is a hang
  initial begin
    repeat (2000) @(posedge i_clock);
    miscompares++;
    $display("CHECK FAILED %0t watchdog", $time);
    report_and_stop;
  end
  initial begin
    i_rst_n = 1'b0;
    bov_seen = 1'b0;
    hold_seen = 1'b0;
    repeat (2) @(posedge i_clock);
    i_rst_n <= 1'b1;
    #1;
    t_reset;
    t_in_shift;
    t_logic;
    t_store;
    t_overflow;
    t_saturate;
    t_mult;
    report_and_stop;
  end
endmodule
